// [dv/dac_update_checker_assertions.sv]
// Port-level assertions of the converter input update control
`timescale 1ns/1ps
`default_nettype none
`include "dac_cfg.svh"

module dac_update_checker (
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Register bus
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // Converter side
    input wire logic [9:0]  converter_value,
    input wire logic        converter_update,
    input wire logic        converter_busy
);
    localparam int CONV = `CONV_CYCLES;
    logic [8:0] busy_cnt_reg;
    logic [8:0] busy_cnt_next;
    logic [7:0] rd_addr_reg;
    logic [7:0] rd_addr_next;

    // Busy length counter and address of the read in flight
    always_comb begin
        busy_cnt_next = converter_busy ? busy_cnt_reg + 9'h001 : 9'h000;
        rd_addr_next  = (s_axi_arvalid && s_axi_arready) ? s_axi_araddr : rd_addr_reg;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            busy_cnt_reg <= 9'h000;
            rd_addr_reg  <= 8'h00;
        end else begin
            busy_cnt_reg <= busy_cnt_next;
            rd_addr_reg  <= rd_addr_next;
        end
    end

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_UPDATE_PULSE: assert property (converter_update |=> !converter_update)
        else $error("update pulse too long");
    AST_VALUE_WITH_UPDATE: assert property (!$stable(converter_value) |-> converter_update)
        else $error("value changed without update");
    AST_TRIGGER_LOAD: assert property ($rose(converter_busy) |-> converter_update)
        else $error("conversion started without load");
    AST_BUSY_SPAN: assert property ($fell(converter_busy) |-> busy_cnt_reg == CONV)
        else $error("conversion length wrong");
    AST_BUSY_CAP: assert property (converter_busy |-> busy_cnt_reg < CONV)
        else $error("conversion runs too long");
    AST_WRITE_RESP: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer late");
    AST_READ_RESP: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    AST_RDATA_HOLD: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
    AST_CTRL_RESERVED: assert property (s_axi_rvalid && rd_addr_reg == `CTRL_OFFSET
        |-> s_axi_rdata[31:8] == 24'h0 && !s_axi_rdata[3] && !s_axi_rdata[1])
        else $error("reserved control bits not zero");
endmodule

bind dac_input_update_control dac_update_checker dac_update_checker_i (.*);
`default_nettype wire

// [dv/tb_top.sv]
// Self-checking bench of the converter input update control
`timescale 1ns/1ps
`default_nettype none
`include "dac_cfg.svh"

module tb_top;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready, converter_enable, converter_update, converter_busy;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, hi_s, lo_s;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [9:0]  converter_value, exp_v;
    logic [4:0]  flags;
    int          failures, checks, cycles;

    dac_input_update_control dac_input_update_control_i (
        .*,
        .cmp0_flag(flags[0]), .cmp1_flag(flags[1]), .ext_int0_flag(flags[2]),
        .tmr1_ovf_flag(flags[3]), .tmr1_cap_flag(flags[4])
    );

    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures = failures + 1;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        if (failures == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            failures = failures + 1;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            n = n + 1;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n < 100);
        check(32'(s_axi_bvalid), 32'h1);
        s_axi_bready <= 1'b0;
        check(32'(s_axi_bresp), 32'(er));
    endtask

    // Ready for read data is raised only once data shows, so the hold is exercised
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            n = n + 1;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) s_axi_rready <= 1'b1;
        end while (!(s_axi_rvalid === 1'b1 && s_axi_rready) && n < 100);
        check(32'(s_axi_rvalid), 32'h1);
        s_axi_rready <= 1'b0;
        check(s_axi_rdata, e);
        check(32'(s_axi_rresp), 32'(er));
    endtask

    task automatic raise(input int idx, output logic seen);
        @(posedge aclk);
        flags <= (idx < 0) ? 5'h1F : (flags | (5'h01 << idx));
        seen = 1'b0;
        repeat (4) begin
            @(posedge aclk);
            #1;
            if (converter_update === 1'b1) seen = 1'b1;
        end
    endtask

    task automatic drop();
        @(posedge aclk);
        flags <= 5'h00;
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        while (converter_busy !== 1'b0 && n < 400) begin
            @(posedge aclk);
            n = n + 1;
        end
        check(32'(converter_busy), 32'h0);
    endtask

    function automatic logic [9:0] align(input logic l, input logic [7:0] h, input logic [7:0] o);
        return l ? {h, o[7:6]} : {h[1:0], o};
    endfunction

    function automatic int src_of(input int t);
        case (t)
            0, 1, 2: return t;
            6: return 3;
            7: return 4;
            default: return -1;
        endcase
    endfunction

    initial begin
        int idx;
        logic l, seen;
        logic [7:0] c, h, lo;
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, flags} = '0;
        {hi_s, lo_s, exp_v} = '0;
        void'($urandom(53));
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`CTRL_OFFSET, 32'h0, `RESP_OKAY);
        rd(`HIGH_OFFSET, 32'h0, `RESP_OKAY);
        rd(`LOW_OFFSET, 32'h0, `RESP_OKAY);
        rd(8'h40, 32'h0, `RESP_SLVERR);
        wr(8'h40, 8'hFF, 4'hF, `RESP_SLVERR);
        wr(`CTRL_OFFSET, 8'hFF, 4'hE, `RESP_OKAY);
        rd(`CTRL_OFFSET, 32'h0, `RESP_OKAY);
        for (int i = 0; i < 24; i++) begin
            l = 1'($urandom);
            c = {1'b0, 3'($urandom), 1'b0, l, 1'b0, 1'($urandom)};
            wr(`CTRL_OFFSET, c | 8'h0A, 4'hF, `RESP_OKAY);
            rd(`CTRL_OFFSET, 32'(c), `RESP_OKAY);
            check(32'(converter_enable), 32'(c[0]));
            check(32'(converter_value), 32'(exp_v));
            lo = 8'($urandom);
            h = 8'($urandom);
            if (i % 3 != 0) begin
                wr(`LOW_OFFSET, lo, 4'hF, `RESP_OKAY);
                lo_s = l ? (lo & 8'hC0) : lo;
                check(32'(converter_value), 32'(exp_v));
            end
            wr(`HIGH_OFFSET, h, 4'hF, `RESP_OKAY);
            hi_s = l ? h : (h & 8'h03);
            exp_v = align(l, hi_s, lo_s);
            check(32'(converter_value), 32'(exp_v));
            rd(`HIGH_OFFSET, 32'(hi_s), `RESP_OKAY);
            rd(`LOW_OFFSET, 32'(l ? (lo_s & 8'hC0) : lo_s), `RESP_OKAY);
        end
        for (int t = 0; t < 8; t++) begin
            idx = src_of(t);
            wr(`CTRL_OFFSET, {1'b1, 3'(t), 4'h1}, 4'hF, `RESP_OKAY);
            lo = 8'($urandom);
            h = 8'($urandom);
            wr(`LOW_OFFSET, lo, 4'hF, `RESP_OKAY);
            wr(`HIGH_OFFSET, h, 4'hF, `RESP_OKAY);
            check(32'(converter_value), 32'(exp_v));
            raise(idx, seen);
            if (idx < 0) begin
                check(32'(seen), 32'h0);
                drop();
            end else begin
                exp_v = align(1'b0, h & 8'h03, lo);
                check(32'(seen), 32'h1);
                check(32'(converter_value), 32'(exp_v));
                h = 8'($urandom);
                wr(`HIGH_OFFSET, h, 4'hF, `RESP_OKAY);
                drop();
                raise(idx, seen);
                check(32'(seen), 32'h0);
                wait_idle();
                repeat (4) @(posedge aclk);
                check(32'(converter_value), 32'(exp_v));
                drop();
                lo = 8'($urandom);
                wr(`LOW_OFFSET, lo, 4'hF, `RESP_OKAY);
                raise(idx, seen);
                check(32'(seen), 32'h0);
                drop();
                wr(`HIGH_OFFSET, h, 4'hF, `RESP_OKAY);
                raise(idx, seen);
                exp_v = align(1'b0, h & 8'h03, lo);
                check(32'(converter_value), 32'(exp_v));
                drop();
                wait_idle();
            end
        end
        report_and_stop();
    end
endmodule
`default_nettype wire

// [hdl/axil_reg_port.sv]
// AXI4-Lite slave front end turning bus transfers into register strobes
`timescale 1ns/1ps
`default_nettype none
`include "dac_cfg.svh"

module axil_reg_port (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // Write address and data
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // Write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // Read address and data
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Register side
    output logic             wr_fire,
    output logic [7:0]       wr_addr,
    output logic [7:0]       wr_data,
    output logic             wr_lane0,
    input  wire logic        wr_ok,
    output logic [7:0]       rd_addr,
    input  wire logic [31:0] rd_data,
    input  wire logic        rd_ok
);

    logic        aw_held_reg, aw_held_next;
    logic        w_held_reg, w_held_next;
    logic [7:0]  awaddr_reg, awaddr_next;
    logic [7:0]  wdata_reg, wdata_next;
    logic        lane0_reg, lane0_next;
    logic        bvalid_reg, bvalid_next;
    logic [1:0]  bresp_reg, bresp_next;
    logic        rvalid_reg, rvalid_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0]  rresp_reg, rresp_next;

    assign s_axi_awready = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready  = !w_held_reg && !bvalid_reg;
    assign s_axi_arready = !rvalid_reg;
    assign wr_fire       = aw_held_reg && w_held_reg;
    assign wr_addr       = awaddr_reg;
    assign wr_data       = wdata_reg;
    assign wr_lane0      = lane0_reg;
    assign rd_addr       = s_axi_araddr;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;

    always_comb begin
        aw_held_next = aw_held_reg;
        w_held_next  = w_held_reg;
        awaddr_next  = awaddr_reg;
        wdata_next   = wdata_reg;
        lane0_next   = lane0_reg;
        bvalid_next  = bvalid_reg;
        bresp_next   = bresp_reg;
        rvalid_next  = rvalid_reg;
        rdata_next   = rdata_reg;
        rresp_next   = rresp_reg;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_held_next = 1'b1;
            awaddr_next  = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_held_next = 1'b1;
            wdata_next  = s_axi_wdata[7:0];
            lane0_next  = s_axi_wstrb[0];
        end
        if (wr_fire) begin
            aw_held_next = 1'b0;
            w_held_next  = 1'b0;
            bvalid_next  = 1'b1;
            bresp_next   = wr_ok ? `RESP_OKAY : `RESP_SLVERR;
        end else if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_next = 1'b1;
            rdata_next  = rd_data;
            rresp_next  = rd_ok ? `RESP_OKAY : `RESP_SLVERR;
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            awaddr_reg  <= 8'h00;
            wdata_reg   <= 8'h00;
            lane0_reg   <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= 2'b00;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= 32'h00000000;
            rresp_reg   <= 2'b00;
        end else begin
            aw_held_reg <= aw_held_next;
            w_held_reg  <= w_held_next;
            awaddr_reg  <= awaddr_next;
            wdata_reg   <= wdata_next;
            lane0_reg   <= lane0_next;
            bvalid_reg  <= bvalid_next;
            bresp_reg   <= bresp_next;
            rvalid_reg  <= rvalid_next;
            rdata_reg   <= rdata_next;
            rresp_reg   <= rresp_next;
        end
    end

endmodule

`default_nettype wire

// [hdl/dac_cfg.svh]
// Register map, field positions, reset values and timing counts of the converter control
`ifndef DAC_CFG_SVH
`define DAC_CFG_SVH

`define CTRL_OFFSET       8'h00
`define HIGH_OFFSET       8'h04
`define LOW_OFFSET        8'h08
`define STATUS_OFFSET     8'h0C

`define ENABLE_BIT        0
`define LEFT_ADJUST_BIT   2
`define TSEL_LSB          4
`define TSEL_MSB          6
`define AUTO_TRIG_BIT     7
`define CTRL_WRITE_MASK   8'hF5

`define CTRL_RESET        8'h00
`define HIGH_RESET        8'h00
`define LOW_RESET         8'h00
`define VALUE_RESET       10'h000

`define HIGH_RIGHT_MASK   8'h03
`define LOW_LEFT_MASK     8'hC0

`define STAT_BUSY_BIT     10
`define STAT_LOCK_BIT     11

`define RESP_OKAY         2'b00
`define RESP_SLVERR       2'b10

`define CLK_PERIOD_NS     4
`define CONV_TIME_NS      1000
`define CONV_CYCLES       ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// [hdl/dac_input_update_control.sv]
// Control of the 10-bit converter input: registers, shadow value and trigger updates
//
// Function
// - Enable bit 0 set drives the converter from the value; cleared disables it.
// - Auto trigger bit 7 and enable bit 0 both set load the converter on a selected source rising edge.
// - A trigger still high after a conversion starts nothing until a new edge.
// - Trigger edges arriving during a triggered conversion are ignored.
// - Three-bit select: comparators 0/1, external interrupt 0, timer overflow, capture.
// - The source flag's rising edge triggers whether or not its interrupt is enabled.
// - Auto trigger cleared: writing the high byte loads both bytes to the converter.
// - A low byte write blocks updates until the high byte is written; low first.
// - Left adjust bit 2 picks alignment; a change acts at the next high byte write.
// - Right alignment: high bits 1:0 hold value 9:8, low byte holds value 7:0.
// - Left alignment: a high byte write alone updates the converter, an 8-bit mode.
// - Left alignment: high holds value 9:2, low bits 7:6 hold value 1:0.
//
// Implementation choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "dac_cfg.svh"

module dac_input_update_control
    import dac_pkg::*;
(
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Peripheral event flags
    input  wire logic        cmp0_flag,
    input  wire logic        cmp1_flag,
    input  wire logic        ext_int0_flag,
    input  wire logic        tmr1_ovf_flag,
    input  wire logic        tmr1_cap_flag,
    // Converter side
    output logic             converter_enable,
    output logic [9:0]       converter_value,
    output logic             converter_update,
    output logic             converter_busy
);

    // Bus strobes
    logic        wr_fire;
    logic [7:0]  wr_addr;
    logic [7:0]  wr_data;
    logic        wr_lane0;
    logic        wr_ok;
    logic [7:0]  rd_addr;
    logic [31:0] rd_data;
    logic        rd_ok;

    // Software visible registers
    logic [7:0]  ctrl_reg, ctrl_next;
    logic [7:0]  high_reg, high_next;
    logic [7:0]  low_reg, low_next;

    // Hidden converter input state
    logic [9:0]  staged_reg, staged_next;
    logic [9:0]  shadow_reg, shadow_next;
    logic        lock_reg, lock_next;
    logic        update_reg, update_next;

    // Triggered conversion timing
    conv_state_t state_reg, state_next;
    logic [7:0]  cnt_reg, cnt_next;

    // Decoded control fields
    logic        auto_trigger_enable;
    logic [2:0]  trigger_select;
    logic        left_adjust;
    logic        trig_edge;
    logic        trig_take;

    // Write decode
    logic        wr_ctrl;
    logic        wr_high;
    logic        wr_low;
    logic [7:0]  high_mask;
    logic [7:0]  low_mask;
    logic [7:0]  high_new;
    logic [9:0]  aligned_new;

    axil_reg_port u_bus (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .wr_fire       (wr_fire),
        .wr_addr       (wr_addr),
        .wr_data       (wr_data),
        .wr_lane0      (wr_lane0),
        .wr_ok         (wr_ok),
        .rd_addr       (rd_addr),
        .rd_data       (rd_data),
        .rd_ok         (rd_ok)
    );

    trigger_edge_select u_trig (
        .aclk           (aclk),
        .aresetn        (aresetn),
        .cmp0_flag      (cmp0_flag),
        .cmp1_flag      (cmp1_flag),
        .ext_int0_flag  (ext_int0_flag),
        .tmr1_ovf_flag  (tmr1_ovf_flag),
        .tmr1_cap_flag  (tmr1_cap_flag),
        .trigger_select (trigger_select),
        .trig_edge      (trig_edge)
    );

    assign auto_trigger_enable = ctrl_reg[`AUTO_TRIG_BIT];
    assign trigger_select      = ctrl_reg[`TSEL_MSB:`TSEL_LSB];
    assign left_adjust         = ctrl_reg[`LEFT_ADJUST_BIT];

    // Unused value bits follow the alignment in force
    assign high_mask = left_adjust ? 8'hFF : `HIGH_RIGHT_MASK;
    assign low_mask  = left_adjust ? `LOW_LEFT_MASK : 8'hFF;

    // Address decoding of writes
    always_comb begin
        wr_ctrl = 1'b0;
        wr_high = 1'b0;
        wr_low  = 1'b0;
        wr_ok   = 1'b1;
        if (wr_addr == `CTRL_OFFSET) begin
            wr_ctrl = wr_fire && wr_lane0;
        end else if (wr_addr == `HIGH_OFFSET) begin
            wr_high = wr_fire && wr_lane0;
        end else if (wr_addr == `LOW_OFFSET) begin
            wr_low = wr_fire && wr_lane0;
        end else if (wr_addr == `STATUS_OFFSET) begin
            wr_ok = 1'b1;
        end else begin
            wr_ok = 1'b0;
        end
    end

    // Address decoding of reads
    always_comb begin
        rd_data = 32'h00000000;
        rd_ok   = 1'b1;
        if (rd_addr == `CTRL_OFFSET) begin
            rd_data[7:0] = ctrl_reg;
        end else if (rd_addr == `HIGH_OFFSET) begin
            rd_data[7:0] = high_reg & high_mask;
        end else if (rd_addr == `LOW_OFFSET) begin
            rd_data[7:0] = low_reg & low_mask;
        end else if (rd_addr == `STATUS_OFFSET) begin
            rd_data[9:0]            = shadow_reg;
            rd_data[`STAT_BUSY_BIT] = (state_reg == CONV_BUSY);
            rd_data[`STAT_LOCK_BIT] = lock_reg;
        end else begin
            rd_ok = 1'b0;
        end
    end

    // New aligned value formed from the incoming high byte
    always_comb begin
        high_new = wr_data & high_mask;
        if (left_adjust) begin
            aligned_new = {high_new, low_reg[7:6]};
        end else begin
            aligned_new = {high_new[1:0], low_reg};
        end
    end

    // Register file
    always_comb begin
        ctrl_next = ctrl_reg;
        high_next = high_reg;
        low_next  = low_reg;
        if (wr_ctrl) begin
            ctrl_next = wr_data & `CTRL_WRITE_MASK;
        end
        if (wr_high) begin
            high_next = high_new;
        end
        if (wr_low) begin
            low_next = wr_data & low_mask;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg <= `CTRL_RESET;
            high_reg <= `HIGH_RESET;
            low_reg  <= `LOW_RESET;
        end else begin
            ctrl_reg <= ctrl_next;
            high_reg <= high_next;
            low_reg  <= low_next;
        end
    end

    // Trigger accepted only when idle, enabled and not held by a lone low write
    assign trig_take = auto_trigger_enable && ctrl_reg[`ENABLE_BIT]
                       && trig_edge && !lock_reg
                       && (state_reg == CONV_IDLE);

    // Shadow value, staged pair and low-byte lock
    always_comb begin
        staged_next = staged_reg;
        shadow_next = shadow_reg;
        lock_next   = lock_reg;
        update_next = 1'b0;
        if (wr_low) begin
            lock_next = 1'b1;
        end
        if (wr_high) begin
            lock_next   = 1'b0;
            staged_next = aligned_new;
            if (!auto_trigger_enable) begin
                shadow_next = aligned_new;
                update_next = 1'b1;
            end
        end
        // A trigger beside a high write still loads, since the busy phase starts
        if (trig_take) begin
            shadow_next = staged_reg;
            update_next = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            staged_reg <= `VALUE_RESET;
            shadow_reg <= `VALUE_RESET;
            lock_reg   <= 1'b0;
            update_reg <= 1'b0;
        end else begin
            staged_reg <= staged_next;
            shadow_reg <= shadow_next;
            lock_reg   <= lock_next;
            update_reg <= update_next;
        end
    end

    // Triggered conversion in progress
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        case (state_reg)
            CONV_IDLE: begin
                if (trig_take) begin
                    state_next = CONV_BUSY;
                    cnt_next   = 8'(`CONV_CYCLES - 1);
                end
            end
            CONV_BUSY: begin
                if (cnt_reg == 8'h00) begin
                    state_next = CONV_IDLE;
                end else begin
                    cnt_next = cnt_reg - 8'h01;
                end
            end
            default: begin
                state_next = CONV_IDLE;
                cnt_next   = 8'h00;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= CONV_IDLE;
            cnt_reg   <= 8'h00;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
        end
    end

    // Converter outputs
    assign converter_enable = ctrl_reg[`ENABLE_BIT];
    assign converter_value  = shadow_reg;
    assign converter_update = update_reg;
    assign converter_busy   = (state_reg == CONV_BUSY);

endmodule

`default_nettype wire

// [hdl/dac_pkg.sv]
// Types shared by the converter control modules
package dac_pkg;

    typedef enum logic [1:0] {
        CONV_IDLE = 2'b01,
        CONV_BUSY = 2'b10
    } conv_state_t;

    typedef enum logic [2:0] {
        TSEL_CMP0     = 3'h0,
        TSEL_CMP1     = 3'h1,
        TSEL_EXT_INT0 = 3'h2,
        TSEL_TMR1_OVF = 3'h6,
        TSEL_TMR1_CAP = 3'h7
    } trig_sel_t;

endpackage

// [hdl/trigger_edge_select.sv]
// Trigger source selection and rising edge detection of the selected flag
`timescale 1ns/1ps
`default_nettype none

module trigger_edge_select
    import dac_pkg::*;
(
    // Clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // Source flags and selection
    input  wire logic       cmp0_flag,
    input  wire logic       cmp1_flag,
    input  wire logic       ext_int0_flag,
    input  wire logic       tmr1_ovf_flag,
    input  wire logic       tmr1_cap_flag,
    input  wire logic [2:0] trigger_select,
    // Detected edge
    output logic            trig_edge
);

    logic sel_flag;
    logic prev_reg;
    logic prev_next;

    always_comb begin
        case (trigger_select)
            TSEL_CMP0:     sel_flag = cmp0_flag;
            TSEL_CMP1:     sel_flag = cmp1_flag;
            TSEL_EXT_INT0: sel_flag = ext_int0_flag;
            TSEL_TMR1_OVF: sel_flag = tmr1_ovf_flag;
            TSEL_TMR1_CAP: sel_flag = tmr1_cap_flag;
            default:       sel_flag = 1'b0;
        endcase
    end

    always_comb begin
        prev_next = sel_flag;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= prev_next;
        end
    end

    // A flag that stays high gives no second edge
    assign trig_edge = sel_flag & ~prev_reg;

endmodule

`default_nettype wire
